// File: hdl/tbcd_decoder.v
// Transmit command decoder with AXI4-Lite register access and payload word output.
// Summary of operation
// - Completion-interrupt bit set: raise done flag once whole buffer is loaded.
// - End alignment 00=4, 01=16, 10=32 bytes, 11 reserved; padding words discarded.
// - Data start offset marks first valid byte; earlier bytes are ignored.
// - Bit 13 set marks the buffer as opening segment of a packet.
// - Bit 12 set marks the buffer as closing segment of the packet.
// - Eleven-bit buffer size with alignment gives count of trailing padding words.
// - Buffer size checked when command is read; zero size is a transmit error.
// - Running size sum is compared with packet length; disagreement sets error.
// - Offset low bits pick first byte lane; upper bits skip up to seven words.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tbcd_regs.vh"

module tbcd_decoder (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`TBCD_ADDR_W-1:0] s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`TBCD_ADDR_W-1:0] s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  output reg                     out_valid,
  output reg  [31:0]             out_data,
  output reg  [3:0]              out_be,
  output reg                     out_sop,
  output reg                     out_eop,
  output wire                    tx_done_flag,
  output wire                    tx_error_flag
);

  // Decoder states.
  localparam [1:0] S_CMDA = 2'h0;
  localparam [1:0] S_CMDB = 2'h1;
  localparam [1:0] S_DATA = 2'h2;

  // Rounds a byte span up to the selected end alignment.
  function [12:0] align_up;
    input [12:0] span;
    input [1:0]  al;
    reg   [12:0] m;
    begin
      m = `TBCD_MASK_4;
      if (al == `TBCD_AL_16) begin
        m = `TBCD_MASK_16;
      end else if (al == `TBCD_AL_32) begin
        m = `TBCD_MASK_32;
      end
      align_up = (span + m) & ~m;
    end
  endfunction

  reg  [1:0]  state_reg;
  reg  [31:0] cmda_reg;
  reg  [10:0] word_idx_reg;
  reg  [10:0] words_total_reg;
  reg  [11:0] sum_reg;
  reg  [10:0] pkt_len_reg;
  reg         in_pkt_reg;
  reg         first_out_reg;
  reg  [1:0]  status_reg;
  reg  [1:0]  status_next;
  reg         ctrl_en_reg;

  wire        wr_fire;
  wire        rd_fire;
  wire        data_wr;
  wire [10:0] a_size;
  wire [4:0]  a_off;
  wire [1:0]  a_align;
  wire [12:0] a_span;
  wire [12:0] a_aligned;
  wire [10:0] a_words;
  wire [3:0]  lane_en;
  wire        last_word;
  wire [11:0] sum_first;
  wire [11:0] sum_more;

  // Write address and data are taken together, one write at a time.
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  // Command words and payload arrive through the data port only while enabled.
  assign data_wr = wr_fire && (s_axi_awaddr == `TBCD_OFF_DATA) && ctrl_en_reg;

  // Fields decoded from the incoming word when it is the first command.
  assign a_size  = s_axi_wdata[`TBCD_A_SIZE_MSB:`TBCD_A_SIZE_LSB];
  assign a_off   = s_axi_wdata[`TBCD_A_OFF_MSB:`TBCD_A_OFF_LSB];
  assign a_align = s_axi_wdata[`TBCD_A_ALIGN_MSB:`TBCD_A_ALIGN_LSB];
  assign a_span  = {8'h00, a_off} + {2'h0, a_size};
  // Words the host supplies, skipped words plus payload plus padding; trailing padding is consumed silently.
  assign a_aligned = align_up(a_span, a_align);
  assign a_words   = a_aligned[12:2];

  // Lane mask of the current payload word from the latched command.
  tbcd_lane_mask u_tbcd_lane_mask (
    .word_idx  (word_idx_reg),
    .start_off (cmda_reg[`TBCD_A_OFF_MSB:`TBCD_A_OFF_LSB]),
    .buf_size  (cmda_reg[`TBCD_A_SIZE_MSB:`TBCD_A_SIZE_LSB]),
    .lane_en   (lane_en)
  );

  assign last_word = (word_idx_reg + 11'h001) == words_total_reg;
  assign sum_first = {1'b0, cmda_reg[`TBCD_A_SIZE_MSB:`TBCD_A_SIZE_LSB]};
  assign sum_more  = sum_reg + sum_first;

  // Decoder state machine and buffer bookkeeping.
  always @(posedge aclk) begin
    if (!aresetn || !ctrl_en_reg) begin
      state_reg       <= S_CMDA;
      cmda_reg        <= 32'h00000000;
      word_idx_reg    <= 11'h000;
      words_total_reg <= 11'h000;
      sum_reg         <= 12'h000;
      pkt_len_reg     <= 11'h000;
      in_pkt_reg      <= 1'b0;
      first_out_reg   <= 1'b0;
    end else if (data_wr) begin
      case (state_reg)
        S_CMDA: begin
          cmda_reg        <= s_axi_wdata;
          words_total_reg <= a_words;
          word_idx_reg    <= 11'h000;
          state_reg       <= S_CMDB;
        end
        S_CMDB: begin
          if (cmda_reg[`TBCD_A_FS]) begin
            sum_reg       <= sum_first;
            pkt_len_reg   <= s_axi_wdata[`TBCD_B_LEN_MSB:`TBCD_B_LEN_LSB];
            in_pkt_reg    <= 1'b1;
            first_out_reg <= 1'b1;
          end else begin
            sum_reg       <= sum_more;
          end
          if (words_total_reg == 11'h000) begin
            state_reg <= S_CMDA;
            if (cmda_reg[`TBCD_A_LS]) begin
              in_pkt_reg <= 1'b0;
            end
          end else begin
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          word_idx_reg <= word_idx_reg + 11'h001;
          if (lane_en != 4'h0) begin
            first_out_reg <= 1'b0;
          end
          if (last_word) begin
            state_reg <= S_CMDA;
            if (cmda_reg[`TBCD_A_LS]) begin
              in_pkt_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= S_CMDA;
        end
      endcase
    end
  end

  // Payload output: only words holding valid bytes leave, padding and skipped words do not.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data  <= 32'h00000000;
      out_be    <= 4'h0;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
    end else begin
      out_valid <= data_wr && (state_reg == S_DATA) && (lane_en != 4'h0);
      if (data_wr && (state_reg == S_DATA)) begin
        out_data <= s_axi_wdata;
        out_be   <= lane_en;
        out_sop  <= first_out_reg && (lane_en != 4'h0);
        out_eop  <= cmda_reg[`TBCD_A_LS] && (lane_en != 4'h0) &&
                    ((lane_en[3] == 1'b0) || last_word ||
                     ({word_idx_reg, 2'h3} + 13'h0001 ==
                      {8'h00, cmda_reg[`TBCD_A_OFF_MSB:`TBCD_A_OFF_LSB]} +
                      {2'h0, cmda_reg[`TBCD_A_SIZE_MSB:`TBCD_A_SIZE_LSB]}));
      end
    end
  end

  // Events that set the sticky flags; hardware set wins over a same-cycle clear.
  reg set_done;
  reg set_err;
  always @* begin
    set_done = 1'b0;
    set_err  = 1'b0;
    if (data_wr && (state_reg == S_CMDA)) begin
      // A zero size or the reserved alignment cannot describe a real buffer.
      if ((a_size == 11'h000) || (a_align == `TBCD_AL_RSV)) begin
        set_err = 1'b1;
      end
    end
    if (data_wr && (state_reg == S_CMDB)) begin
      if (!cmda_reg[`TBCD_A_FS]) begin
        // Continuation needs an open packet and the same packet length as before.
        if (!in_pkt_reg ||
            (s_axi_wdata[`TBCD_B_LEN_MSB:`TBCD_B_LEN_LSB] != pkt_len_reg)) begin
          set_err = 1'b1;
        end
      end else if (in_pkt_reg) begin
        set_err = 1'b1;
      end
    end
    if (data_wr && (((state_reg == S_DATA) && last_word) ||
                    ((state_reg == S_CMDB) && (words_total_reg == 11'h000)))) begin
      set_done = cmda_reg[`TBCD_A_IOC];
      if (cmda_reg[`TBCD_A_LS]) begin
        // Length comparison happens when the closing buffer is complete.
        if (state_reg == S_CMDB) begin
          if ((cmda_reg[`TBCD_A_FS] ? sum_first : sum_more) != {1'b0, pkt_len_reg}) begin
            set_err = 1'b1;
          end
        end else if (sum_reg != {1'b0, pkt_len_reg}) begin
          set_err = 1'b1;
        end
      end
    end
  end

  // Status flags are write-one-to-clear.
  always @* begin
    status_next = status_reg;
    if (wr_fire && (s_axi_awaddr == `TBCD_OFF_STATUS) && s_axi_wstrb[0]) begin
      status_next = status_reg & ~s_axi_wdata[`TBCD_ST_ERR:`TBCD_ST_DONE];
    end
    if (set_done) begin
      status_next[`TBCD_ST_DONE] = 1'b1;
    end
    if (set_err) begin
      status_next[`TBCD_ST_ERR] = 1'b1;
    end
  end

  // Status and control registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg  <= 2'h0;
      ctrl_en_reg <= 1'b1;
    end else begin
      status_reg <= status_next;
      if (wr_fire && (s_axi_awaddr == `TBCD_OFF_CTRL) && s_axi_wstrb[0]) begin
        ctrl_en_reg <= s_axi_wdata[`TBCD_CTRL_EN];
      end
    end
  end

  assign tx_done_flag  = status_reg[`TBCD_ST_DONE];
  assign tx_error_flag = status_reg[`TBCD_ST_ERR];

  // Write response; unmapped addresses answer with a slave error.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TBCD_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if ((s_axi_awaddr == `TBCD_OFF_DATA) || (s_axi_awaddr == `TBCD_OFF_STATUS) ||
          (s_axi_awaddr == `TBCD_OFF_CTRL)) begin
        s_axi_bresp <= `TBCD_RESP_OKAY;
      end else begin
        s_axi_bresp <= `TBCD_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data; the data port is write-only and reads as zero.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TBCD_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TBCD_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == `TBCD_OFF_DATA) begin
        s_axi_rdata <= 32'h00000000;
      end else if (s_axi_araddr == `TBCD_OFF_STATUS) begin
        s_axi_rdata <= {27'h0000000, in_pkt_reg, state_reg, status_reg};
      end else if (s_axi_araddr == `TBCD_OFF_CTRL) begin
        s_axi_rdata <= {31'h00000000, ctrl_en_reg};
      end else if (s_axi_araddr == `TBCD_OFF_CMDA) begin
        s_axi_rdata <= cmda_reg;
      end else if (s_axi_araddr == `TBCD_OFF_SUM) begin
        s_axi_rdata <= {20'h00000, sum_reg};
      end else begin
        s_axi_rresp <= `TBCD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: hdl/tbcd_regs.vh
// Register map, command word fields and timing-free constants of the transmit command decoder.
`ifndef TBCD_REGS_VH
`define TBCD_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define TBCD_ADDR_W          8
`define TBCD_OFF_DATA        8'h00
`define TBCD_OFF_STATUS      8'h04
`define TBCD_OFF_CTRL        8'h08
`define TBCD_OFF_CMDA        8'h0c
`define TBCD_OFF_SUM         8'h10

// Status register bits.
`define TBCD_ST_DONE         0
`define TBCD_ST_ERR          1
`define TBCD_ST_STATE_LO     2
`define TBCD_ST_STATE_HI     3
`define TBCD_ST_INPKT        4

// Control register bits and reset value.
`define TBCD_CTRL_EN         0
`define TBCD_CTRL_RESET      2'h1

// First command word fields.
`define TBCD_A_IOC           31
`define TBCD_A_RSV_HI_MSB    30
`define TBCD_A_RSV_HI_LSB    26
`define TBCD_A_ALIGN_MSB     25
`define TBCD_A_ALIGN_LSB     24
`define TBCD_A_OFF_MSB       20
`define TBCD_A_OFF_LSB       16
`define TBCD_A_FS            13
`define TBCD_A_LS            12
`define TBCD_A_SIZE_MSB      10
`define TBCD_A_SIZE_LSB      0

// Second command word packet length field.
`define TBCD_B_LEN_MSB       10
`define TBCD_B_LEN_LSB       0

// End alignment codes and their rounding masks in bytes.
`define TBCD_AL_4            2'h0
`define TBCD_AL_16           2'h1
`define TBCD_AL_32           2'h2
`define TBCD_AL_RSV          2'h3
`define TBCD_MASK_4          13'h0003
`define TBCD_MASK_16         13'h000f
`define TBCD_MASK_32         13'h001f

// AXI response codes.
`define TBCD_RESP_OKAY       2'h0
`define TBCD_RESP_SLVERR     2'h2

`endif

// File: hdl/tbcd_lane_mask.v
// Byte lane mask of one payload word from data start offset and buffer size.
`timescale 1ns/1ps
`default_nettype none

module tbcd_lane_mask (
  input  wire [10:0] word_idx,
  input  wire [4:0]  start_off,
  input  wire [10:0] buf_size,
  output wire [3:0]  lane_en
);

  // Last valid byte position plus one, widened so the sum cannot wrap.
  wire [12:0] end_pos;
  assign end_pos = {8'h00, start_off} + {2'h0, buf_size};

  // A lane carries payload when its byte position lies in [offset, offset+size).
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      // An integer constant carries the lane number, since a loop index cannot be bit-selected.
      localparam integer LANE = i;
      wire [12:0] pos;
      assign pos        = {word_idx, LANE[1:0]};
      assign lane_en[i] = (pos >= {8'h00, start_off}) && (pos < end_pos);
    end
  endgenerate

endmodule

`default_nettype wire

// File: sim/tbcd_decoder_sva.sv
// Concurrent checks on the ports of the transmit command decoder.
`timescale 1ns/1ps
`default_nettype none
`include "tbcd_regs.vh"

module tbcd_decoder_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic       s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       out_valid,
  input wire logic [3:0] out_be,
  input wire logic       out_sop,
  input wire logic       out_eop,
  input wire logic       tx_done_flag,
  input wire logic       tx_error_flag
);
  logic wr_take;
  logic wtake_q;
  logic clr_done;
  logic clr_err;

  // A clear through STATUS is the only legal way for a sticky flag to drop outside reset.
  assign wr_take  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign clr_done = wr_take && s_axi_awaddr == `TBCD_OFF_STATUS && s_axi_wstrb[0] && s_axi_wdata[`TBCD_ST_DONE];
  assign clr_err  = wr_take && s_axi_awaddr == `TBCD_OFF_STATUS && s_axi_wstrb[0] && s_axi_wdata[`TBCD_ST_ERR];

  // Beats and flag sets can only follow a taken write, so remember the last edge's take.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wtake_q <= 1'b0;
    end else begin
      wtake_q <= wr_take;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_answer; wr_take |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_rd_answer; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_beat_cause; out_valid |-> wtake_q && s_axi_bvalid && out_be != 4'h0; endproperty
  a_beat_cause: assert property (p_beat_cause) else $error("beat without a write");
  property p_beat_pulse; out_valid |=> !out_valid; endproperty
  a_beat_pulse: assert property (p_beat_pulse) else $error("beat longer than a cycle");
  property p_done_hold; tx_done_flag && !clr_done |=> tx_done_flag; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  property p_err_hold; tx_error_flag && !clr_err |=> tx_error_flag; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");
  property p_done_cause; $rose(tx_done_flag) |-> wtake_q; endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without a write");
  property p_err_cause; $rose(tx_error_flag) |-> wtake_q; endproperty
  a_err_cause: assert property (p_err_cause) else $error("error without a write");

  c_sop: cover property (out_valid && out_sop);
  c_eop: cover property (out_valid && out_eop);
  c_err: cover property ($rose(tx_error_flag));
endmodule
`default_nettype wire

// File: sim/tbcd_sink.sv
// Far-side sink that records the payload beats of the decoder.
`timescale 1ns/1ps
`default_nettype none

module tbcd_sink (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic [3:0]  out_be,
  input  wire logic        out_sop,
  input  wire logic        out_eop,
  output var  logic [15:0] beats,
  output var  logic [31:0] last_data,
  output var  logic [3:0]  last_be,
  output var  logic        last_sop,
  output var  logic        last_eop
);
  // The stream has no ready, so every beat is taken in the one cycle it is offered.
  always @(posedge aclk) begin
    if (!aresetn) begin
      beats <= 16'h0000;
    end else if (out_valid) begin
      beats     <= beats + 16'h0001;
      last_data <= out_data;
      last_be   <= out_be;
      last_sop  <= out_sop;
      last_eop  <= out_eop;
    end
  end
endmodule
`default_nettype wire

// File: sim/tbcd_decoder_tb.sv
// Self-checking bench for the transmit command decoder.
`timescale 1ns/1ps
`default_nettype none
`include "tbcd_regs.vh"

module tbcd_decoder_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, out_valid, out_sop, out_eop;
  logic tx_done_flag, tx_error_flag, last_sop, last_eop;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, out_data, last_data;
  logic [3:0]  s_axi_wstrb, out_be, last_be;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] beats, b0;
  int          n_fail, n_compared, ab, nw;
  logic [1:0]  t_al [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic [4:0]  t_of [5] = '{5'h00, 5'h00, 5'h00, 5'h05, 5'h1f};
  logic [10:0] t_sz [5] = '{11'h005, 11'h005, 11'h005, 11'h003, 11'h001};
  logic [3:0]  t_be [5] = '{4'h1, 4'h1, 4'h1, 4'he, 4'h8};
  logic [1:0]  t_nb [5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1};

  tbcd_decoder u_tbcd_decoder (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .out_valid,
    .out_data, .out_be, .out_sop, .out_eop, .tx_done_flag, .tx_error_flag);
  tbcd_sink u_tbcd_sink (.aclk, .aresetn, .out_valid, .out_data, .out_be, .out_sop, .out_eop, .beats,
    .last_data, .last_be, .last_sop, .last_eop);

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // The #1 at the end lets the answering edge's updates land before anything is compared.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `TBCD_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = `TBCD_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    #1;
  endtask

  // Reserved fields of the first command word are always sent as zero.
  function automatic logic [31:0] mk(input logic [1:0] al, input logic [4:0] of, input logic fs, input logic ls,
                                     input logic [10:0] sz);
    mk = {1'b0, 5'h00, al, 3'h0, of, 2'h0, fs, ls, 1'b0, sz};
  endfunction

  // Command A, then command B, then the payload words.
  task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input int n);
    wr(`TBCD_OFF_DATA, a);
    wr(`TBCD_OFF_DATA, b);
    repeat (n) wr(`TBCD_OFF_DATA, 32'h5a5a_a5a5);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles at most.
  initial begin
    #300000;
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    report_and_stop();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0000_0000;
    s_axi_wstrb  = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TBCD_OFF_STATUS, 32'h0000_0000);
    rd(`TBCD_OFF_CTRL, 32'h0000_0001);
    // One-buffer packet, offset one byte, four bytes, completion flag requested.
    send_buf(mk(2'h0, 5'h01, 1'b1, 1'b1, 11'h004) | 32'h8000_0000, 32'h0000_0004, 0);
    wr(`TBCD_OFF_DATA, 32'haabb_ccdd);
    chk(last_be, 4'he);
    chk(last_sop, 1'b1);
    chk(last_eop, 1'b0);
    chk(last_data, 32'haabb_ccdd);
    chk(tx_done_flag, 1'b0);
    wr(`TBCD_OFF_DATA, 32'h1122_3344);
    chk(last_be, 4'h1);
    chk(last_sop, 1'b0);
    chk(last_eop, 1'b1);
    chk(tx_done_flag, 1'b1);
    rd(`TBCD_OFF_STATUS, 32'h0000_0001);
    rd(`TBCD_OFF_SUM, 32'h0000_0004);
    rd(`TBCD_OFF_CMDA, 32'h8001_3004);
    wr(`TBCD_OFF_STATUS, 32'h0000_0001);
    rd(`TBCD_OFF_STATUS, 32'h0000_0000);
    // Every non-reserved alignment code, word skips and the last byte lane; padding gives no beats.
    for (int i = 0; i < 5; i++) begin
      ab = (t_al[i] == 2'h0) ? 4 : (t_al[i] == 2'h1) ? 16 : 32;
      nw = (t_of[i] + t_sz[i] + ab - 1) / ab * ab / 4;
      b0 = beats;
      send_buf(mk(t_al[i], t_of[i], 1'b1, 1'b1, t_sz[i]), {21'h0, t_sz[i]}, nw);
      chk(beats - b0, t_nb[i]);
      chk(last_be, t_be[i]);
      rd(`TBCD_OFF_STATUS, 32'h0000_0000);
    end
    // Three segments whose sizes add up to the length, then three that fall one short.
    for (int k = 0; k < 2; k++) begin
      send_buf(mk(2'h0, 5'h00, 1'b1, 1'b0, 11'h004), 32'h0000_000c + k, 1);
      rd(`TBCD_OFF_STATUS, 32'h0000_0010);
      send_buf(mk(2'h0, 5'h00, 1'b0, 1'b0, 11'h004), 32'h0000_000c + k, 1);
      rd(`TBCD_OFF_STATUS, 32'h0000_0010);
      send_buf(mk(2'h0, 5'h00, 1'b0, 1'b1, 11'h004), 32'h0000_000c + k, 1);
      rd(`TBCD_OFF_SUM, 32'h0000_000c);
      chk(tx_error_flag, k[0]);
    end
    wr(`TBCD_OFF_STATUS, 32'h0000_0002);
    // Reserved alignment code, then a zero buffer size.
    send_buf(mk(2'h3, 5'h00, 1'b1, 1'b1, 11'h004), 32'h0000_0004, 1);
    rd(`TBCD_OFF_STATUS, 32'h0000_0002);
    wr(`TBCD_OFF_STATUS, 32'h0000_0002);
    send_buf(mk(2'h0, 5'h00, 1'b1, 1'b1, 11'h000), 32'h0000_0000, 0);
    rd(`TBCD_OFF_STATUS, 32'h0000_0002);
    wr(`TBCD_OFF_STATUS, 32'h0000_0002);
    rd(`TBCD_OFF_STATUS, 32'h0000_0000);
    // Unmapped address, and data written while the decoder is disabled.
    rd(8'h20, 32'h0000_0000, `TBCD_RESP_SLVERR);
    wr(8'h20, 32'hffff_ffff, `TBCD_RESP_SLVERR);
    wr(`TBCD_OFF_CTRL, 32'h0000_0000);
    wr(`TBCD_OFF_DATA, mk(2'h0, 5'h00, 1'b1, 1'b1, 11'h004));
    rd(`TBCD_OFF_STATUS, 32'h0000_0000);
    wr(`TBCD_OFF_CTRL, 32'h0000_0001);
    report_and_stop();
  end
endmodule

bind tbcd_decoder tbcd_decoder_sva u_tbcd_decoder_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .out_valid, .out_be, .out_sop, .out_eop, .tx_done_flag,
  .tx_error_flag);
`default_nettype wire
